// ==== frequent_start_limiter.sv ====
// frequent start limiter: start counter, lockout, events and log
// assumes an APB master on mclk and a one-cycle start pulse
`timescale 1ns/100ps
`default_nettype none
module frequent_start_limiter
   import start_limit_pkg::*;
#(
   parameter int TICK_CYCLES = PROG_CYCLE_CYCLES,
   parameter int DEPTH = LOG_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // motor side
   input wire logic start_pulse,
   input wire logic block_in,
   input wire logic thermal_valid,
   input wire logic [LIMIT_W-1:0] thermal_level,
   input wire logic [STAMP_W-1:0] clock_ms,
   // protection outputs
   output logic alarm,
   output logic lockout,
   output logic blocked,
   output var cond_t condition,
   output var motor_data_t motor_data,
   // event stream
   output logic evt_valid,
   output logic [EV_W-1:0] evt_code,
   output logic [STAMP_W-1:0] evt_stamp
);
   localparam int PTR_W = $clog2(DEPTH);

   if (TICK_CYCLES < 2 || TICK_CYCLES > 1073741824) begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end
   if (DEPTH < 2 || DEPTH > 256) begin : g_bad_depth
      $error("DEPTH out of range");
   end

   // program cycle tick
   logic [31:0] tick_cnt;
   logic tick;
   wire tick_wrap = (tick_cnt == 32'(TICK_CYCLES - 1));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick_cnt <= tick_wrap ? '0 : tick_cnt + 32'h1;
         tick <= tick_wrap;
      end
   end

   // settings and apb decode
   mode_t mode;
   logic cold_set;
   logic [NEV-1:0] evt_sel;
   logic [PTR_W-1:0] log_idx;
   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr = access & pwrite & ~pslverr;
   wire rd_hit = paddr inside {OFS_MODE, OFS_HOT_LIMIT, OFS_STALL_COLD, OFS_STALL_HOT,
      OFS_STARTS_COLD, OFS_STARTS_HOT, OFS_HOURS, OFS_MIN_GAP, OFS_EVT_SEL, OFS_STATUS,
      OFS_COUNT, OFS_LOG_IDX, OFS_LOG_STAMP_LO, OFS_LOG_STAMP_HI, OFS_LOG_EVENT,
      OFS_LOG_LOCK, OFS_LOG_SINCE};
   wire gap_hit = (paddr == OFS_STALL_HOT) || (paddr == OFS_MIN_GAP);
   wire cnt_hit = (paddr == OFS_STARTS_COLD) || (paddr == OFS_STARTS_HOT);
   wire wdata_ok =
      (paddr == OFS_MODE) ? ($onehot(pwdata[MODE_W-1:0]) && pwdata[31:MODE_W] == '0) :
      (paddr == OFS_HOT_LIMIT) ? (pwdata <= LIMIT_MAX) :
      (paddr == OFS_STALL_COLD) ? (pwdata <= STALL_MAX) :
      gap_hit ? (pwdata != '0 && pwdata <= STALL_MAX) :
      cnt_hit ? (pwdata != '0 && pwdata <= STARTS_MAX) :
      (paddr == OFS_HOURS) ? (pwdata != '0 && pwdata <= HOURS_MAX) :
      (paddr == OFS_EVT_SEL) ? (pwdata <= EVT_SEL_MAX) :
      (paddr == OFS_LOG_IDX) ? (pwdata < 32'(DEPTH)) : 1'b0;
   wire req_err = pwrite ? ~wdata_ok : ~rd_hit;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MODE_ON;
         motor_data <= MOTOR_DATA_DEF;
         cold_set <= 1'b1;
         evt_sel <= EVT_SEL_DEF;
         log_idx <= '0;
      end else if (wr) begin
         case (paddr)
            OFS_MODE: mode <= mode_t'(pwdata[MODE_W-1:0]);
            OFS_HOT_LIMIT: motor_data.hot_limit <= pwdata[LIMIT_W-1:0];
            OFS_STALL_COLD: begin
               motor_data.stall_cold <= pwdata[SET_W-1:0];
               cold_set <= (pwdata != '0);
            end
            OFS_STALL_HOT: motor_data.stall_hot <= pwdata[SET_W-1:0];
            OFS_STARTS_COLD: motor_data.starts_cold <= pwdata[CNT_W-1:0];
            OFS_STARTS_HOT: motor_data.starts_hot <= pwdata[CNT_W-1:0];
            OFS_HOURS: motor_data.hours <= pwdata[CNT_W-1:0];
            OFS_MIN_GAP: motor_data.min_gap <= pwdata[SET_W-1:0];
            OFS_EVT_SEL: evt_sel <= pwdata[NEV-1:0];
            OFS_LOG_IDX: log_idx <= pwdata[PTR_W-1:0];
            default: ;
         endcase
      end
   end

   // start counter: a partly drained start still counts as used
   logic [USED_W-1:0] used;
   logic [USED_W-1:0] next_used;
   logic [UNIT_W-1:0] resid;
   logic [UNIT_W-1:0] next_resid;
   wire run = (mode == MODE_ON || mode == MODE_TEST) & ~block_in;
   wire is_hot = thermal_valid & (thermal_level > motor_data.hot_limit);
   wire [SET_W-1:0] cold_stall = cold_set ? motor_data.stall_cold : motor_data.stall_hot;
   wire [SET_W-1:0] stall_sel = is_hot ? motor_data.stall_hot : cold_stall;
   wire [CNT_W-1:0] allow = is_hot ? motor_data.starts_hot : motor_data.starts_cold;
   wire [WIN_W-1:0] win_ticks = WIN_W'(motor_data.hours) * WIN_W'(TICKS_PER_HOUR);
   wire [UNIT_W-1:0] unit = UNIT_W'(stall_sel) * UNIT_W'(win_ticks);
   wire [UNIT_W-1:0] decay = UNIT_W'(allow) * UNIT_W'(stall_sel);
   wire [UNIT_W-1:0] drained = resid + decay;
   wire [USED_W-1:0] avail = (USED_W'(allow) > used) ? USED_W'(allow) - used : '0;
   wire start_ok = start_pulse & run;

   always_comb begin
      next_used = used;
      next_resid = resid;
      if (start_ok) begin
         next_used = (used == USED_MAX) ? used : used + USED_W'(1);
      end else if (tick) begin
         if (used == '0) begin
            next_resid = '0;
         end else if (drained >= unit) begin
            next_used = used - USED_W'(1);
            next_resid = drained - unit;
         end else begin
            next_resid = drained;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         used <= '0;
         resid <= '0;
      end else begin
         used <= next_used;
         resid <= next_resid;
      end
   end

   // start gap, time since start, lockout time
   logic [TIME_W-1:0] since;
   logic [TIME_W-1:0] lock_time;
   logic gap_lock;
   wire too_soon = since < TIME_W'(motor_data.min_gap);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         since <= '1;
         gap_lock <= 1'b0;
      end else if (start_ok) begin
         since <= '0;
         gap_lock <= gap_lock | too_soon;
      end else if (tick) begin
         since <= (since == '1) ? since : since + TIME_W'(1);
         gap_lock <= gap_lock & too_soon;
      end
   end

   // outputs and condition
   wire next_alarm = run & (avail == USED_W'(1));
   wire next_lock = run & ((avail == '0) | gap_lock);
   wire mode_blk = (mode == MODE_BLOCKED) || (mode == MODE_TEST_BLOCKED);
   wire next_blocked = (mode != MODE_OFF) & (block_in | mode_blk);
   cond_t next_cond;
   assign next_cond = next_blocked ? COND_BLOCKED : next_lock ? COND_TRIP :
      next_alarm ? COND_START : COND_NORMAL;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         alarm <= 1'b0;
         lockout <= 1'b0;
         blocked <= 1'b0;
         condition <= COND_NORMAL;
         lock_time <= '0;
      end else begin
         alarm <= next_alarm;
         lockout <= next_lock;
         blocked <= next_blocked;
         condition <= next_cond;
         if (next_lock & ~lockout) begin
            lock_time <= '0;
         end else if (tick & lockout & (lock_time != '1)) begin
            lock_time <= lock_time + TIME_W'(1);
         end
      end
   end

   // event queue: one event taken per cycle, lowest code first
   logic [NEV-1:0] pend;
   logic [NEV-1:0] take;
   logic [EV_W-1:0] take_code;
   wire [NSRC-1:0] src_lv = {blocked, lockout, alarm};
   assign take = pend & (~pend + 6'h01);

   for (genvar i = 0; i < NSRC; i++) begin : g_edge
      event_edge u_edge (
         .mclk(mclk),
         .rst_n(rst_n),
         .level(src_lv[i]),
         .take_on(take[2*i]),
         .take_off(take[2*i+1]),
         .pend_on(pend[2*i]),
         .pend_off(pend[2*i+1])
      );
   end

   always_comb begin
      take_code = '0;
      for (int k = 0; k < NEV; k++) begin
         if (take[k]) take_code = EV_W'(k);
      end
   end

   // rolling log
   log_rec_t log_mem [DEPTH];
   log_rec_t rec;
   log_rec_t rl;
   logic [PTR_W-1:0] wr_ptr;
   wire log_we = |pend;
   wire ptr_last = (wr_ptr == PTR_W'(DEPTH - 1));
   assign rec = '{stamp: clock_ms, code: take_code, lock_time: lock_time,
      since_start: since, used: used};
   assign rl = log_mem[log_idx];

   always_ff @(posedge mclk) begin
      if (log_we) log_mem[wr_ptr] <= rec;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         evt_valid <= 1'b0;
         evt_code <= '0;
         evt_stamp <= '0;
      end else begin
         if (log_we) wr_ptr <= ptr_last ? '0 : wr_ptr + PTR_W'(1);
         evt_valid <= log_we & evt_sel[take_code];
         if (log_we) begin
            evt_code <= take_code;
            evt_stamp <= clock_ms;
         end
      end
   end

   // read mux and apb answer
   wire [31:0] rd_mux =
      (paddr == OFS_MODE) ? 32'(mode) :
      (paddr == OFS_HOT_LIMIT) ? 32'(motor_data.hot_limit) :
      (paddr == OFS_STALL_COLD) ? (cold_set ? 32'(motor_data.stall_cold) : 32'h0) :
      (paddr == OFS_STALL_HOT) ? 32'(motor_data.stall_hot) :
      (paddr == OFS_STARTS_COLD) ? 32'(motor_data.starts_cold) :
      (paddr == OFS_STARTS_HOT) ? 32'(motor_data.starts_hot) :
      (paddr == OFS_HOURS) ? 32'(motor_data.hours) :
      (paddr == OFS_MIN_GAP) ? 32'(motor_data.min_gap) :
      (paddr == OFS_EVT_SEL) ? 32'(evt_sel) :
      (paddr == OFS_STATUS) ? 32'({mode, condition, is_hot, blocked, lockout, alarm}) :
      (paddr == OFS_COUNT) ? 32'({avail, used}) :
      (paddr == OFS_LOG_IDX) ? 32'(log_idx) :
      (paddr == OFS_LOG_STAMP_LO) ? rl.stamp[31:0] :
      (paddr == OFS_LOG_STAMP_HI) ? rl.stamp[63:32] :
      (paddr == OFS_LOG_EVENT) ? 32'({rl.used, 5'h00, rl.code}) :
      (paddr == OFS_LOG_LOCK) ? rl.lock_time :
      (paddr == OFS_LOG_SINCE) ? rl.since_start : 32'h0;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & req_err;
         if (setup & ~pwrite) prdata <= rd_mux;
      end
   end

   // checks
   a_alarm_one_left: assert property (@(posedge mclk) disable iff (!rst_n)
      (run && avail == USED_W'(1)) |=> alarm)
      else $error("alarm missing with one start left");
   a_lock_all_used: assert property (@(posedge mclk) disable iff (!rst_n)
      (run && avail == '0) |=> lockout)
      else $error("lockout missing with no start left");
   a_blocked_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      (mode == MODE_BLOCKED) |=> blocked)
      else $error("blocked output missing in blocked mode");
   a_gap_lockout: assert property (@(posedge mclk) disable iff (!rst_n)
      (start_ok && too_soon) ##1 run |=> lockout)
      else $error("early start did not lock out");
   a_start_charge: assert property (@(posedge mclk) disable iff (!rst_n)
      (start_ok && used != USED_MAX) |=> used == $past(used) + USED_W'(1))
      else $error("start did not charge the counter");
   a_log_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
      (log_we && ptr_last) |=> wr_ptr == '0)
      else $error("log pointer did not wrap");
   a_log_stamp: assert property (@(posedge mclk) disable iff (!rst_n)
      log_we |=> log_mem[$past(wr_ptr)].stamp == $past(clock_ms))
      else $error("log record stamp wrong");
   a_event_masked: assert property (@(posedge mclk) disable iff (!rst_n)
      (log_we && !evt_sel[take_code]) |=> !evt_valid)
      else $error("deselected event was emitted");
   a_lock_event: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(lockout) |-> ##[1:8] (log_we && take_code == EV_LOCK_ON))
      else $error("lockout rise not logged");
   a_cold_default: assert property (@(posedge mclk) disable iff (!rst_n)
      (!cold_set && !is_hot) |-> decay == UNIT_W'(allow) * UNIT_W'(motor_data.stall_hot))
      else $error("unset cold stall time not following hot");
   a_drain_step: assert property (@(posedge mclk) disable iff (!rst_n)
      (tick && !start_ok && used != '0 && drained >= unit) |=>
      used == $past(used) - USED_W'(1))
      else $error("fully drained start not released");
   a_off_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      (mode == MODE_OFF) |=> (!blocked && !alarm && !lockout))
      else $error("outputs active in off mode");
   a_tick_single: assert property (@(posedge mclk) disable iff (!rst_n)
      tick |=> !tick)
      else $error("program tick longer than one cycle");
   a_idle_no_charge: assert property (@(posedge mclk) disable iff (!rst_n)
      (start_pulse && !run) |=> used <= $past(used))
      else $error("start charged while not running");
   a_gap_release: assert property (@(posedge mclk) disable iff (!rst_n)
      (tick && !start_ok && !too_soon) |=> !gap_lock)
      else $error("start gap lock not released");
endmodule
`default_nettype wire

// ==== start_limit_pkg.sv ====
// constants, types and register map of the frequent start limiter
// assumes a 100 MHz mclk and a 100 ms program cycle derived from it
package start_limit_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_CYCLE_MS = 100;
   localparam int PROG_CYCLE_CYCLES = PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TICKS_PER_HOUR = 36000;
   localparam int LOG_DEPTH = 12;
   // widths
   localparam int ADDR_W = 8;
   localparam int LIMIT_W = 10;
   localparam int SET_W = 13;
   localparam int CNT_W = 7;
   localparam int MODE_W = 5;
   localparam int USED_W = 8;
   localparam int WIN_W = 24;
   localparam int UNIT_W = 40;
   localparam int TIME_W = 32;
   localparam int STAMP_W = 64;
   localparam int EV_W = 3;
   localparam int NSRC = 3;
   localparam int NEV = 6;
   // setting ranges
   localparam logic [31:0] LIMIT_MAX = 32'h000003E8;
   localparam logic [31:0] STALL_MAX = 32'h00001770;
   localparam logic [31:0] STARTS_MAX = 32'h00000064;
   localparam logic [31:0] HOURS_MAX = 32'h00000064;
   localparam logic [31:0] EVT_SEL_MAX = 32'h0000003F;
   localparam logic [USED_W-1:0] USED_MAX = 8'hFF;
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_HOT_LIMIT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STALL_COLD = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STALL_HOT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STARTS_COLD = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STARTS_HOT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_HOURS = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_MIN_GAP = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_EVT_SEL = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_LOG_IDX = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_LOG_STAMP_LO = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_LOG_STAMP_HI = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_LOG_EVENT = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_LOG_LOCK = 8'h3C;
   localparam logic [ADDR_W-1:0] OFS_LOG_SINCE = 8'h40;
   // event codes: source index times two, plus one for off
   localparam logic [EV_W-1:0] EV_ALARM_ON = 3'h0;
   localparam logic [EV_W-1:0] EV_ALARM_OFF = 3'h1;
   localparam logic [EV_W-1:0] EV_LOCK_ON = 3'h2;
   localparam logic [EV_W-1:0] EV_LOCK_OFF = 3'h3;
   localparam logic [EV_W-1:0] EV_BLK_ON = 3'h4;
   localparam logic [EV_W-1:0] EV_BLK_OFF = 3'h5;
   localparam logic [NEV-1:0] EVT_SEL_DEF = 6'h3F;

   typedef enum logic [MODE_W-1:0] {
      MODE_ON = 5'h01,
      MODE_BLOCKED = 5'h02,
      MODE_TEST = 5'h04,
      MODE_TEST_BLOCKED = 5'h08,
      MODE_OFF = 5'h10
   } mode_t;

   typedef enum logic [3:0] {
      COND_NORMAL = 4'h1,
      COND_START = 4'h2,
      COND_TRIP = 4'h4,
      COND_BLOCKED = 4'h8
   } cond_t;

   typedef struct packed {
      logic [LIMIT_W-1:0] hot_limit;
      logic [SET_W-1:0] stall_cold;
      logic [SET_W-1:0] stall_hot;
      logic [CNT_W-1:0] starts_cold;
      logic [CNT_W-1:0] starts_hot;
      logic [CNT_W-1:0] hours;
      logic [SET_W-1:0] min_gap;
   } motor_data_t;

   localparam motor_data_t MOTOR_DATA_DEF = '{
      hot_limit: 10'h2BC,
      stall_cold: 13'h00C8,
      stall_hot: 13'h0096,
      starts_cold: 7'h03,
      starts_hot: 7'h02,
      hours: 7'h01,
      min_gap: 13'h00C8
   };

   typedef struct packed {
      logic [STAMP_W-1:0] stamp;
      logic [EV_W-1:0] code;
      logic [TIME_W-1:0] lock_time;
      logic [TIME_W-1:0] since_start;
      logic [USED_W-1:0] used;
   } log_rec_t;
endpackage

// ==== event_edge.sv ====
// edge watcher with pending on/off flags for one output
// assumes the taker clears at most one flag per cycle
`timescale 1ns/100ps
`default_nettype none
module event_edge (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // watched level
   input wire logic level,
   // queue handshake
   input wire logic take_on,
   input wire logic take_off,
   output logic pend_on,
   output logic pend_off
);
   logic prev;
   wire rise = level & ~prev;
   wire fall = ~level & prev;

   // a new edge wins over a take in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
         pend_on <= 1'b0;
         pend_off <= 1'b0;
      end else begin
         prev <= level;
         pend_on <= rise | (pend_on & ~take_on);
         pend_off <= fall | (pend_off & ~take_off);
      end
   end
endmodule
`default_nettype wire

// ==== motor_side_model.sv ====
// model of the motor status and thermal overload functions
// assumes the bench asks for a start with a one-cycle kick
`timescale 1ns/100ps
`default_nettype none
module motor_side_model
   import start_limit_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // bench requests
   input wire logic kick,
   input wire logic therm_en,
   input wire logic hot,
   // towards the limiter
   output logic start_pulse,
   output logic thermal_valid,
   output logic [LIMIT_W-1:0] thermal_level,
   output logic [STAMP_W-1:0] clock_ms
);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_pulse <= 1'b0;
         thermal_valid <= 1'b0;
         clock_ms <= 64'h0;
      end else begin
         start_pulse <= kick;
         thermal_valid <= therm_en;
         clock_ms <= clock_ms + 64'h1;
      end
   end
   // level means nothing while not valid, so it wanders
   assign thermal_level = thermal_valid ? (hot ? 10'h3E8 : 10'h064) : clock_ms[9:0];
endmodule
`default_nettype wire

// ==== frequent_start_limiter_tb.sv ====
// self-checking bench of the frequent start limiter over apb
// assumes a short program tick of four mclk cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module frequent_start_limiter_tb;
   import start_limit_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic start_pulse;
   logic block_in = 1'b0;
   logic thermal_valid;
   logic [LIMIT_W-1:0] thermal_level;
   logic [STAMP_W-1:0] clock_ms;
   logic alarm;
   logic lockout;
   logic blocked;
   cond_t condition;
   motor_data_t motor_data;
   logic evt_valid;
   logic [EV_W-1:0] evt_code;
   logic [STAMP_W-1:0] evt_stamp;
   logic kick = 1'b0;
   logic therm_en = 1'b0;
   logic hot = 1'b0;
   logic [31:0] rdat;
   logic rerr;
   int miscompares = 0;
   int n_tests = 0;
   logic [EV_W-1:0] evq[$];
   logic [31:0] defs [11] = '{32'h1, 32'h2BC, 32'hC8, 32'h96, 32'h3, 32'h2, 32'h1, 32'hC8,
      32'h3F, 32'h110, 32'h300};
   logic [40:0] bad [12] = '{{8'h04, 32'h3E9, 1'b1}, {8'h04, 32'h3E8, 1'b0},
      {8'h08, 32'h1771, 1'b1}, {8'h08, 32'h0, 1'b0}, {8'h0C, 32'h0, 1'b1},
      {8'h10, 32'h65, 1'b1}, {8'h14, 32'h64, 1'b0}, {8'h18, 32'h0, 1'b1},
      {8'h1C, 32'h1771, 1'b1}, {8'h00, 32'h3, 1'b1}, {8'h24, 32'h0, 1'b1},
      {8'h84, 32'h0, 1'b1}};

   always #5 mclk = ~mclk;

   frequent_start_limiter #(.TICK_CYCLES(4), .DEPTH(LOG_DEPTH)) i_frequent_start_limiter (
      .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .start_pulse(start_pulse), .block_in(block_in),
      .thermal_valid(thermal_valid), .thermal_level(thermal_level), .clock_ms(clock_ms),
      .alarm(alarm), .lockout(lockout), .blocked(blocked), .condition(condition),
      .motor_data(motor_data), .evt_valid(evt_valid), .evt_code(evt_code),
      .evt_stamp(evt_stamp));

   motor_side_model i_motor_side_model (
      .mclk(mclk), .rst_n(rst_n), .kick(kick), .therm_en(therm_en), .hot(hot),
      .start_pulse(start_pulse), .thermal_valid(thermal_valid),
      .thermal_level(thermal_level), .clock_ms(clock_ms));

   // event stream watcher
   always @(posedge mclk) begin
      if (rst_n && evt_valid === 1'b1) begin
         evq.push_back(evt_code);
         `CHK(evt_stamp, clock_ms - 64'h1)
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask

   task automatic start_motor;
      @(posedge mclk);
      kick <= 1'b1;
      @(posedge mclk);
      kick <= 1'b0;
      cyc(20);
   endtask

   task automatic do_reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      cyc(6);
      rst_n <= 1'b1;
      cyc(2);
      evq.delete();
   endtask

   task automatic ev_chk(input int n, input logic [8:0] codes);
      `CHK(evq.size(), n)
      for (int i = 0; i < n && i < evq.size(); i++) begin
         `CHK(evq[i], codes[3*i +: 3])
      end
      evq.delete();
   endtask

   task conclude;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      conclude();
   end

   initial begin
      do_reset();
      // defaults, refusals and modes
      for (int i = 0; i < 11; i++) begin
         rd(ADDR_W'(4 * i), defs[i]);
      end
      `CHK(motor_data, MOTOR_DATA_DEF)
      `CHK(condition, COND_NORMAL)
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, bad[i][40:33], bad[i][32:1]);
         `CHK(rerr, bad[i][0])
      end
      rd(OFS_STALL_COLD, 32'h0);
      `CHK(motor_data.hot_limit, 10'h3E8)
      `CHK(motor_data.starts_hot, 7'h64)
      rd(8'h84, 32'h0);
      `CHK(rerr, 1'b1)
      for (int i = 0; i < 5; i++) begin
         wr(OFS_MODE, 32'h1 << i);
         rd(OFS_MODE, 32'h1 << i);
      end
      // cold starts up to lockout, then log wrap
      do_reset();
      wr(OFS_MIN_GAP, 32'h1);
      start_motor();
      rd(OFS_COUNT, 32'h201);
      `CHK(alarm, 1'b0)
      start_motor();
      rd(OFS_COUNT, 32'h102);
      `CHK(alarm, 1'b1)
      `CHK(condition, COND_START)
      start_motor();
      rd(OFS_COUNT, 32'h003);
      `CHK(lockout, 1'b1)
      `CHK(alarm, 1'b0)
      `CHK(condition, COND_TRIP)
      start_motor();
      rd(OFS_COUNT, 32'h004);
      `CHK(lockout, 1'b1)
      ev_chk(3, {EV_LOCK_ON, EV_ALARM_OFF, EV_ALARM_ON});
      for (int i = 0; i < 5; i++) begin
         block_in <= 1'b1;
         cyc(10);
         block_in <= 1'b0;
         cyc(10);
      end
      wr(OFS_LOG_IDX, 32'h0);
      rd(OFS_LOG_EVENT, 32'h404);
      wr(OFS_LOG_IDX, 32'h1);
      rd(OFS_LOG_EVENT, 32'h402);
      rd(OFS_LOG_STAMP_HI, 32'h0);
      // hot and cold allowance
      do_reset();
      wr(OFS_MIN_GAP, 32'h1);
      therm_en <= 1'b1;
      hot <= 1'b1;
      cyc(4);
      start_motor();
      rd(OFS_COUNT, 32'h101);
      `CHK(alarm, 1'b1)
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rdat[3], 1'b1)
      hot <= 1'b0;
      cyc(10);
      rd(OFS_COUNT, 32'h201);
      therm_en <= 1'b0;
      hot <= 1'b1;
      cyc(10);
      rd(OFS_COUNT, 32'h201);
      // early start and decay
      do_reset();
      wr(OFS_STARTS_COLD, 32'h64);
      start_motor();
      start_motor();
      `CHK(lockout, 1'b1)
      rd(OFS_COUNT, 32'h6202);
      cyc(1000);
      `CHK(lockout, 1'b0)
      rd(OFS_COUNT, 32'h6202);
      cyc(2000);
      rd(OFS_COUNT, 32'h6400);
      // blocking, modes and event selection
      do_reset();
      wr(OFS_MIN_GAP, 32'h1);
      wr(OFS_EVT_SEL, 32'h15);
      block_in <= 1'b1;
      cyc(10);
      `CHK(blocked, 1'b1)
      `CHK(condition, COND_BLOCKED)
      start_motor();
      rd(OFS_COUNT, 32'h300);
      block_in <= 1'b0;
      cyc(10);
      `CHK(blocked, 1'b0)
      wr(OFS_MODE, 32'h2);
      cyc(4);
      `CHK(blocked, 1'b1)
      wr(OFS_MODE, 32'h8);
      cyc(4);
      `CHK(blocked, 1'b1)
      wr(OFS_MODE, 32'h10);
      block_in <= 1'b1;
      cyc(10);
      `CHK(blocked, 1'b0)
      block_in <= 1'b0;
      wr(OFS_MODE, 32'h4);
      start_motor();
      rd(OFS_COUNT, 32'h201);
      ev_chk(2, {3'h0, EV_BLK_ON, EV_BLK_ON});
      conclude();
   end
endmodule
`default_nettype wire
